// *** design/pdg_top.sv ***
`timescale 1ns/1ps

// ****************************************************************
// apb register bank and gain selection for both loops
// ****************************************************************
// Notes on behaviour
// - main enable zero disables second detector
// - enable one picks gain by lock mode
// - aux analog above 8 kHz uses bits 6:4
// - main analog high reference uses bits 6:4
// - aux digital feedback uses bits 2:0
// - auto disabled always applies digital gain
// - main analog low reference uses damping 6:4
module pdg_top
	import pdg_pkg::*;
#(
	parameter int ADDR_W = 12 // apb address width
)(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire pdg_pkg::pdg_mode_e main_loop_mode,
	input  wire pdg_pkg::pdg_mode_e aux_loop_mode,
	output logic                   main_loop_pd_en,
	output pdg_pkg::pdg_gain_t     main_loop_pd_gain,
	output logic                   aux_loop_pd_en,
	output pdg_pkg::pdg_gain_t     aux_loop_pd_gain,
	output logic [2:0]             main_loop_damping
);
	import pdg_pkg::*;

	// ************************************************************
	// elaboration check
	// ************************************************************
	if (ADDR_W < 10 || ADDR_W > 32) begin : g_chk
		$error("pdg_top: ADDR_W must be 10 to 32");
	end

	// ************************************************************
	// register state
	// ************************************************************
	logic [7:0]  main_cfg_q;    // main loop gain config
	logic [7:0]  main_cfg_d;
	logic [7:0]  aux_cfg_q;     // aux loop gain config
	logic [7:0]  aux_cfg_d;
	logic [7:0]  damping_q;     // main loop damping config
	logic [7:0]  damping_d;
	logic [31:0] prdata_q;      // registered read data
	logic [31:0] prdata_d;
	logic        err_q;         // registered error answer
	logic        err_d;
	logic [7:0]  status;        // applied gains view
	logic        access;        // access phase this cycle
	logic        wr_en;         // write with low lane enabled
	logic        hit;           // address maps to a register
	logic [7:0]  idx;           // word index
	logic        aligned;       // word aligned, in range

	assign access  = psel && penable;
	assign idx     = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'b00) &&
		(ADDR_W == 10 || paddr[ADDR_W-1:10] == '0);
	assign wr_en   = access && pwrite && pstrb[0];

	// address decode
	always_comb begin
		hit = 1'b0;
		if (aligned) begin
			case (idx)
				PDG_IDX_DAMPING, PDG_IDX_AUX, PDG_IDX_MAIN,
				PDG_IDX_STATUS: begin
					hit = 1'b1;
				end
				default: begin
					hit = 1'b0;
				end
			endcase
		end
	end

	// status word from the applied gains
	always_comb begin
		status = '0;
		status[PDG_ST_MAIN_EN] = main_loop_pd_en;
		status[PDG_ST_MAIN_GAIN +: PDG_GAIN_W] = main_loop_pd_gain;
		status[PDG_ST_AUX_EN] = aux_loop_pd_en;
		status[PDG_ST_AUX_GAIN +: PDG_GAIN_W] = aux_loop_pd_gain;
	end

	// next register values; unused bits masked
	always_comb begin
		main_cfg_d = main_cfg_q;
		aux_cfg_d  = aux_cfg_q;
		damping_d  = damping_q;
		if (wr_en && hit) begin
			case (idx)
				PDG_IDX_MAIN: begin
					main_cfg_d = pwdata[7:0] & PDG_MASK_GAIN;
				end
				PDG_IDX_AUX: begin
					aux_cfg_d = pwdata[7:0] & PDG_MASK_GAIN;
				end
				PDG_IDX_DAMPING: begin
					damping_d = pwdata[7:0] & PDG_MASK_DAMPING;
				end
				default: begin
					damping_d = damping_q; // status is read only
				end
			endcase
		end
	end

	// read data and error for the next cycle's answer
	always_comb begin
		prdata_d = '0;
		err_d    = 1'b0;
		if (psel && !penable) begin
			err_d = !hit;
			if (!pwrite && hit) begin
				case (idx)
					PDG_IDX_MAIN: begin
						prdata_d[7:0] = main_cfg_q;
					end
					PDG_IDX_AUX: begin
						prdata_d[7:0] = aux_cfg_q;
					end
					PDG_IDX_DAMPING: begin
						prdata_d[7:0] = damping_q;
					end
					default: begin
						prdata_d[7:0] = status;
					end
				endcase
			end
		end else if (access) begin
			prdata_d = prdata_q;
			err_d    = err_q;
		end
	end

	// register flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_cfg_q <= PDG_RST_MAIN;
			aux_cfg_q  <= PDG_RST_AUX;
			damping_q  <= PDG_RST_DAMPING;
			prdata_q   <= '0;
			err_q      <= 1'b0;
		end else begin
			main_cfg_q <= main_cfg_d;
			aux_cfg_q  <= aux_cfg_d;
			damping_q  <= damping_d;
			prdata_q   <= prdata_d;
			err_q      <= err_d;
		end
	end

	// ************************************************************
	// apb answer: one access cycle, no wait states
	// ************************************************************
	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = access && err_q;
	assign main_loop_damping = damping_q[2:0];

	// ************************************************************
	// gain selection per loop
	// ************************************************************
	pdg_gain_sel u_main_sel (
		.pclk         (pclk),
		.presetn      (presetn),
		.auto_en      (main_cfg_q[PDG_AUTO_EN_BIT]),
		.lock_mode    (main_loop_mode),
		.analog_gain  (main_cfg_q[PDG_ANA_LSB +: PDG_GAIN_W]),
		.low_gain     (damping_q[PDG_LOW_LSB +: PDG_GAIN_W]),
		.digital_gain (main_cfg_q[PDG_DIG_LSB +: PDG_GAIN_W]),
		.pd_en        (main_loop_pd_en),
		.pd_gain      (main_loop_pd_gain)
	);

	// aux loop has no low-reference field; analog field serves both
	pdg_gain_sel u_aux_sel (
		.pclk         (pclk),
		.presetn      (presetn),
		.auto_en      (aux_cfg_q[PDG_AUTO_EN_BIT]),
		.lock_mode    (aux_loop_mode),
		.analog_gain  (aux_cfg_q[PDG_ANA_LSB +: PDG_GAIN_W]),
		.low_gain     (aux_cfg_q[PDG_ANA_LSB +: PDG_GAIN_W]),
		.digital_gain (aux_cfg_q[PDG_DIG_LSB +: PDG_GAIN_W]),
		.pd_en        (aux_loop_pd_en),
		.pd_gain      (aux_loop_pd_gain)
	);

endmodule

// *** design/pdg_pkg.sv ***
// ****************************************************************
// shared constants for the phase detector gain block
// ****************************************************************
package pdg_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] PDG_IDX_DAMPING = 8'h6B; // main loop damping
	localparam logic [7:0] PDG_IDX_AUX     = 8'h6C; // aux loop gain cfg
	localparam logic [7:0] PDG_IDX_MAIN    = 8'h6D; // main loop gain cfg
	localparam logic [7:0] PDG_IDX_STATUS  = 8'h7E; // applied gain status

	// reset values
	localparam logic [7:0] PDG_RST_DAMPING = 8'h13;
	localparam logic [7:0] PDG_RST_AUX     = 8'hC2;
	localparam logic [7:0] PDG_RST_MAIN    = 8'hC2;

	// writable bit masks; unused bits read as zero
	localparam logic [7:0] PDG_MASK_GAIN    = 8'hF7; // bit 3 unused
	localparam logic [7:0] PDG_MASK_DAMPING = 8'h77; // bits 7, 3 unused

	// field positions inside gain and damping registers
	localparam int PDG_AUTO_EN_BIT = 7; // automatic gain enable
	localparam int PDG_ANA_LSB     = 4; // analog gain, bits 6:4
	localparam int PDG_DIG_LSB     = 0; // digital gain, bits 2:0
	localparam int PDG_LOW_LSB     = 4; // low-ref gain in damping 6:4
	localparam int PDG_GAIN_W      = 3; // width of every gain field

	// status register layout
	localparam int PDG_ST_MAIN_EN   = 7;
	localparam int PDG_ST_MAIN_GAIN = 4;
	localparam int PDG_ST_AUX_EN    = 3;
	localparam int PDG_ST_AUX_GAIN  = 0;

	// locking mode reported by each loop's datapath
	typedef enum logic [1:0] {
		PDG_MODE_DIGITAL,
		PDG_MODE_ANALOG_HIGH,
		PDG_MODE_ANALOG_LOW
	} pdg_mode_e;

	typedef logic [PDG_GAIN_W-1:0] pdg_gain_t;

endpackage

// *** design/pdg_gain_sel.sv ***
`timescale 1ns/1ps

// ****************************************************************
// gain selection for one loop's second phase detector
// ****************************************************************
module pdg_gain_sel
	import pdg_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             auto_en,      // automatic gain enable
	input  wire pdg_mode_e        lock_mode,    // loop locking mode
	input  wire pdg_pkg::pdg_gain_t analog_gain,  // above 8 kHz, analog
	input  wire pdg_pkg::pdg_gain_t low_gain,     // 8 kHz or less, analog
	input  wire pdg_pkg::pdg_gain_t digital_gain, // digital feedback
	output logic                  pd_en,        // detector in use
	output pdg_pkg::pdg_gain_t    pd_gain       // applied gain
);

	logic      en_d;   // next enable
	pdg_gain_t gain_d; // next gain

	// pick gain from locking mode
	always_comb begin
		en_d   = auto_en;
		gain_d = digital_gain;
		if (auto_en) begin
			case (lock_mode)
				PDG_MODE_DIGITAL: begin
					gain_d = digital_gain;
				end
				PDG_MODE_ANALOG_HIGH: begin
					gain_d = analog_gain;
				end
				PDG_MODE_ANALOG_LOW: begin
					gain_d = low_gain;
				end
				default: begin
					gain_d = digital_gain;
				end
			endcase
		end
	end

	// register outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_en   <= 1'b0;
			pd_gain <= '0;
		end else begin
			pd_en   <= en_d;
			pd_gain <= gain_d;
		end
	end

endmodule

// *** tb/pdg_top_sva.sv ***
`timescale 1ns/1ps
// ****************************************
// shadow registers and applied gain checks
// ****************************************
module pdg_top_sva
	import pdg_pkg::*;
#(
	parameter int ADDR_W = 12 // apb address width
)(
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [ADDR_W-1:0]  paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [3:0]         pstrb,
	input wire logic [31:0]        prdata,
	input wire pdg_pkg::pdg_mode_e main_loop_mode,
	input wire pdg_pkg::pdg_mode_e aux_loop_mode,
	input wire logic               main_loop_pd_en,
	input wire pdg_pkg::pdg_gain_t main_loop_pd_gain,
	input wire pdg_pkg::pdg_gain_t aux_loop_pd_gain
);
	localparam logic [ADDR_W-1:0] A_MAIN = ADDR_W'({PDG_IDX_MAIN, 2'b00});
	localparam logic [ADDR_W-1:0] A_AUX  = ADDR_W'({PDG_IDX_AUX, 2'b00});
	localparam logic [ADDR_W-1:0] A_DMP  = ADDR_W'({PDG_IDX_DAMPING, 2'b00});
	logic [7:0] main_q, main_d, aux_q, aux_d, dmp_q, dmp_d; // shadow copies
	logic [7:0] wd;                                          // low data lane
	logic       wr;                                          // write accepted
	logic       live_q;                                      // edge since reset
	assign wd = pwdata[7:0];
	assign wr = psel && penable && pwrite && pstrb[0];
	// next shadow values; unused bits masked off
	always_comb begin
		main_d = (wr && paddr == A_MAIN) ? wd & PDG_MASK_GAIN : main_q;
		aux_d  = (wr && paddr == A_AUX) ? wd & PDG_MASK_GAIN : aux_q;
		dmp_d  = (wr && paddr == A_DMP) ? wd & PDG_MASK_DAMPING : dmp_q;
	end
	// shadow state, reset to the register defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			{main_q, aux_q, dmp_q} <= {PDG_RST_MAIN, PDG_RST_AUX, PDG_RST_DAMPING};
		else
			{main_q, aux_q, dmp_q} <= {main_d, aux_d, dmp_d};
	end
	// checks start one edge after release; the releasing edge still
	// sees the design in reset, so no attempt may begin on it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			live_q <= 1'b0;
		else
			live_q <= 1'b1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !live_q);
	a_main_off: assert property (!main_q[7] |=> !main_loop_pd_en)
		else $error("main detector on while disabled");
	a_main_dig: assert property (main_q[7] && main_loop_mode ==
		PDG_MODE_DIGITAL |=> main_loop_pd_en &&
		main_loop_pd_gain == $past(main_q[2:0])) else $error("main digital");
	a_aux_hi: assert property (aux_q[7] && aux_loop_mode ==
		PDG_MODE_ANALOG_HIGH |=> aux_loop_pd_gain == $past(aux_q[6:4]))
		else $error("aux analog gain");
	a_main_hi: assert property (main_q[7] && main_loop_mode ==
		PDG_MODE_ANALOG_HIGH |=> main_loop_pd_gain == $past(main_q[6:4]))
		else $error("main analog gain");
	a_aux_dig: assert property (aux_q[7] && aux_loop_mode ==
		PDG_MODE_DIGITAL |=> aux_loop_pd_gain == $past(aux_q[2:0]))
		else $error("aux digital gain");
	a_off_dig: assert property (!main_q[7] |=>
		main_loop_pd_gain == $past(main_q[2:0])) else $error("off gain");
	a_rd_main: assert property (psel && penable && !pwrite &&
		paddr == A_MAIN |-> prdata == {24'h0, main_q}) else $error("readback");
	a_main_lo: assert property (main_q[7] && main_loop_mode ==
		PDG_MODE_ANALOG_LOW |=> main_loop_pd_gain == $past(dmp_q[6:4]))
		else $error("main low gain");
endmodule

bind pdg_top pdg_top_sva #(.ADDR_W(ADDR_W)) i_sva (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.prdata, .main_loop_mode, .aux_loop_mode, .main_loop_pd_en,
	.main_loop_pd_gain, .aux_loop_pd_gain
);

// *** tb/pdg_top_tb.sv ***
`timescale 1ns/1ps
// ****************************************
// bench for the gain register bank
// ****************************************
module pdg_top_tb;
	import pdg_pkg::*;
	localparam logic [11:0] A_DMP = 12'h1AC, A_AUX = 12'h1B0,
		A_MAIN = 12'h1B4, A_STAT = 12'h1F8; // byte addresses
	logic        pclk, pready, pslverr, men, aen;
	logic        presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0]  pstrb = 4'h0;
	pdg_gain_t   mg, ag;
	logic [2:0]  dmp;  // damping field output
	pdg_mode_e   m_mode = PDG_MODE_DIGITAL, a_mode = PDG_MODE_DIGITAL;
	int          num_errors = 0, n_tests = 0, cyc = 0;

	pdg_top #(.ADDR_W(12)) i_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
		.main_loop_mode(m_mode), .aux_loop_mode(a_mode),
		.main_loop_pd_en(men), .main_loop_pd_gain(mg),
		.aux_loop_pd_en(aen), .aux_loop_pd_gain(ag),
		.main_loop_damping(dmp));

	initial begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end
	// cut a hang short
	always @(posedge pclk) if (++cyc == 2000) begin
		num_errors++;
		wrap_up();
	end
	task automatic chk(input string nm, logic [31:0] ex, logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			$display("ERROR %s expected %h seen %h", nm, ex, got);
			num_errors++;
		end
	endtask
	task automatic wrap_up();
		if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// one apb transfer, answer judged at the pready edge
	task automatic acc(input logic w, logic [11:0] a, logic [7:0] d,
		logic [3:0] s, logic [7:0] ex, logic ee);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		if (!w) chk("prdata", {24'h0, ex}, prdata);
		chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// set both loop modes, wait out the register stage, compare
	task automatic pd(input pdg_mode_e mo, ao, logic [7:0] ex);
		@(posedge pclk);
		m_mode <= mo;
		a_mode <= ao;
		repeat (2) @(posedge pclk);
		#1 chk("pd_out", {24'h0, ex}, {24'h0, men, mg, aen, ag});
	endtask
	task automatic t_reset();
		acc(1'h0, A_AUX, 8'h00, 4'hF, 8'hC2, 1'h0);
		acc(1'h0, A_MAIN, 8'h00, 4'hF, 8'hC2, 1'h0);
		acc(1'h0, A_DMP, 8'h00, 4'hF, 8'h13, 1'h0);
		chk("damping", 32'h3, {29'h0, dmp});
		pd(PDG_MODE_DIGITAL, PDG_MODE_DIGITAL, 8'hAA);
	endtask
	// reset in mid-run brings back the defaults
	task automatic t_mid_rst();
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		acc(1'h0, A_MAIN, 8'h00, 4'hF, 8'hC2, 1'h0);
		acc(1'h0, A_DMP, 8'h00, 4'hF, 8'h13, 1'h0);
		chk("damping", 32'h3, {29'h0, dmp});
		pd(PDG_MODE_ANALOG_HIGH, PDG_MODE_ANALOG_LOW, 8'hCC);
	endtask
	task automatic t_gain();
		acc(1'h1, A_MAIN, 8'hDB, 4'hF, 8'h00, 1'h0);
		acc(1'h0, A_MAIN, 8'h00, 4'hF, 8'hD3, 1'h0);
		acc(1'h1, A_DMP, 8'hF7, 4'hF, 8'h00, 1'h0);
		acc(1'h0, A_DMP, 8'h00, 4'hF, 8'h77, 1'h0);
		chk("damping", 32'h7, {29'h0, dmp});
		pd(PDG_MODE_DIGITAL, PDG_MODE_DIGITAL, 8'hBA);
		pd(PDG_MODE_ANALOG_HIGH, PDG_MODE_ANALOG_HIGH, 8'hDC);
		pd(PDG_MODE_ANALOG_LOW, PDG_MODE_ANALOG_LOW, 8'hFC);
		pd(pdg_mode_e'(2'h3), pdg_mode_e'(2'h3), 8'hBA);
		acc(1'h1, A_MAIN, 8'h5B, 4'hF, 8'h00, 1'h0);
		acc(1'h1, A_AUX, 8'h26, 4'hF, 8'h00, 1'h0);
		pd(PDG_MODE_ANALOG_HIGH, PDG_MODE_ANALOG_LOW, 8'h36);
	endtask
	task automatic t_err();
		acc(1'h1, 12'h000, 8'hFF, 4'hF, 8'h00, 1'h1);
		acc(1'h0, 12'h1B1, 8'h00, 4'hF, 8'h00, 1'h1);
		acc(1'h1, A_AUX, 8'hFF, 4'hE, 8'h00, 1'h0);
		acc(1'h0, A_AUX, 8'h00, 4'hF, 8'h26, 1'h0);
		acc(1'h0, A_STAT, 8'h00, 4'hF, 8'h36, 1'h0);
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_gain();
		t_err();
		t_mid_rst();
		wrap_up();
	end
endmodule
